/* File: inc/pot_pkg.sv */
/*
 Constants for the prescaled overflow timer: register map, field positions,
 reset values, timing counts and prescaler codes.
 Assumes a Wishbone classic slave with 8-bit data in the low lane.
*/
// What this block does
// - 16-bit count plus 8-bit prescaler, byte addressable
// - Source select one internal, zero external pin
// - Edge select picks rising or falling pin edge
// - Prescale codes 0-7 powers of two, 1xxx 256
// - Count wraps FFFF to 0000, sets overflow flag
// - Overflow request gated by its enable bit
// - Overflow flag cleared on vector acknowledge
// - Prescaler output sampled, synchronised after prescaler
// - Pin edge to increment within 3..7 periods
// - Written byte holds one cycle, other counts
// - Any count byte write clears prescaler
// - One count byte per access
// - Prescale may change anytime, clearing advised
// - Interrupt-edge bit picks external interrupt edge
// - Selected pin edge sets external-clock flag, external source only
`default_nettype none
package pot_pkg;
   localparam logic [3:0] REG_CONTROL     = 4'h5;
   localparam logic [3:0] REG_CPU_STATUS  = 4'h6;
   localparam logic [3:0] REG_INT_STATUS  = 4'h7;
   localparam logic [3:0] REG_COUNT_LOW   = 4'hb;
   localparam logic [3:0] REG_COUNT_HIGH  = 4'hc;
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [7:0] INT_RESET       = 8'h00;
   localparam logic [7:0] CPU_RESET       = 8'h00;
   localparam int CTL_IRQ_EDGE  = 7;
   localparam int CTL_CLK_EDGE  = 6;
   localparam int CTL_CLK_SRC   = 5;
   localparam int CTL_PS_HI     = 4;
   localparam int CTL_PS_LO     = 1;
   localparam int INT_PERIPH_FL = 7;
   localparam int INT_EXTCLK_FL = 6;
   localparam int INT_OVF_FL    = 5;
   localparam int INT_PIN_FL    = 4;
   localparam int INT_PERIPH_EN = 3;
   localparam int INT_EXTCLK_EN = 2;
   localparam int INT_OVF_EN    = 1;
   localparam int INT_PIN_EN    = 0;
   localparam int CPU_GLOBAL_DIS = 4;
   localparam logic [7:0] CTL_WMASK = 8'hfe;
   localparam logic [7:0] CPU_WMASK = 8'h10;
   // One instruction cycle is four oscillator periods, one mclk each
   localparam logic [1:0] PHASE_LAST      = 2'h3;
   localparam logic [1:0] PHASE_SAMPLE_A  = 2'h0;
   localparam logic [1:0] PHASE_SAMPLE_B  = 2'h2;
   localparam int LAT_MIN_OSC = 3;
   localparam int LAT_MAX_OSC = 7;
   localparam logic [7:0] PS_MAX = 8'hff;
endpackage
`default_nettype wire

/* File: verilog/pot_prescaler.sv */
/*
 Eight-bit prescaler for the overflow timer: divides a stream of source
 pulses by 1..256 and toggles its output each completed period.
 Assumes pulses are single mclk cycles in the mclk domain.
*/
`default_nettype none
module pot_prescaler
   import pot_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       srcPulse,
   input  wire logic       clearCount,
   input  wire logic [3:0] prescaleSel,
   output logic            prescalerOut
);
   typedef struct packed {
      logic [7:0] count;
      logic       out;
   } pot_ps_type;

   pot_ps_type state;
   pot_ps_type next_state;

   function automatic logic [7:0] ps_limit(input logic [3:0] sel);
      if (sel[3])
         return PS_MAX;
      return 8'((9'h001 << sel[2:0]) - 9'h001);
   endfunction

   always_comb begin
      next_state = state;
      if (clearCount) begin
         next_state.count = '0;
      end else if (srcPulse) begin
         // Wrap at or past the limit when the ratio shrinks on the fly
         if (state.count >= ps_limit(prescaleSel)) begin
            next_state.count = '0;
            next_state.out   = ~state.out;
         end else begin
            next_state.count = state.count + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst)
         state <= '0;
      else
         state <= next_state;
   end

   assign prescalerOut = state.out;

   AST_PS_DIV1: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (srcPulse && !clearCount && prescaleSel == 4'h0) |=> (prescalerOut != $past(prescalerOut)))
      else $error("prescaler at 1:1 missed an edge");
   AST_PS_CLEAR: assert property (
      @(posedge mclk) disable iff (sys_rst)
      clearCount |=> state.count == 8'h00)
      else $error("prescaler not cleared");
endmodule
`default_nettype wire

/* File: verilog/pot_timer.sv */
/*
 Prescaled 16-bit overflow timer with Wishbone classic register access.
 Holds control, cpu status, interrupt status and the two count bytes.
 Assumes pins arrive asynchronously; the core pulses vectorAck when it
 vectors to the overflow interrupt.
*/
`default_nettype none
module pot_timer
   import pot_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic        extClkPin,
   input  wire logic        extIrqPin,
   input  wire logic        vectorAck,
   output logic             overflowIrq,
   output logic             extClkIrq,
   output logic             extPinIrq,
   output logic             globalIrqDisable
);
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01,
      BUS_ERR  = 2'b11
   } pot_bus_type;

   typedef struct packed {
      pot_bus_type bus;
      logic [7:0]  rdata;
      logic [7:0]  control;
      logic [7:0]  cpuStatus;
      logic [7:0]  intStatus;
      logic [7:0]  countLow;
      logic [7:0]  countHigh;
      logic        holdLow;
      logic        holdHigh;
      logic [1:0]  phase;
      logic [1:0]  clkSync;
      logic [1:0]  irqSync;
      logic        clkPrev;
      logic        irqPrev;
      logic        psSample;
      logic        psPrev;
   } pot_state_type;

   pot_state_type state;
   pot_state_type next_state;

   logic       prescalerOut;
   logic       srcPulse;
   logic       psClear;
   logic       access;
   logic       wrAccess;
   logic [3:0] regIdx;
   logic       regValid;
   logic       pinRise;
   logic       pinFall;
   logic       pinEdge;
   logic       extEdge;
   logic       incLow;
   logic       incHigh;
   logic       overflow;
   logic       irqEdge;

   // Printed offsets are not word multiples, so byte address is 4x index
   function automatic logic is_reg(input logic [3:0] idx);
      return idx == REG_CONTROL || idx == REG_CPU_STATUS || idx == REG_INT_STATUS ||
             idx == REG_COUNT_LOW || idx == REG_COUNT_HIGH;
   endfunction

   assign regIdx   = wb_adr_i[5:2];
   assign regValid = is_reg(regIdx);
   assign access   = wb_cyc_i && wb_stb_i && state.bus == BUS_IDLE;
   // Only lane 0 carries the byte; one count byte per access
   assign wrAccess = access && wb_we_i && wb_sel_i[0] && regValid;

   assign pinRise = state.clkSync[1] && !state.clkPrev;
   assign pinFall = !state.clkSync[1] && state.clkPrev;
   assign pinEdge = state.control[CTL_CLK_EDGE] ? pinRise : pinFall;

   // Internal source gives one pulse per instruction cycle
   assign srcPulse = state.control[CTL_CLK_SRC] ? (state.phase == PHASE_LAST) : pinEdge;
   assign psClear  = wrAccess && (regIdx == REG_COUNT_LOW || regIdx == REG_COUNT_HIGH);

   pot_prescaler u_prescaler (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .srcPulse    (srcPulse),
      .clearCount  (psClear),
      .prescaleSel (state.control[CTL_PS_HI:CTL_PS_LO]),
      .prescalerOut(prescalerOut)
   );

   // Prescaler output sampled twice per cycle, any change is one count
   assign extEdge  = state.psSample != state.psPrev;
   assign incLow   = extEdge && !state.holdLow;
   assign incHigh  = extEdge && (state.countLow == 8'hff) && !state.holdHigh;
   assign overflow = incHigh && (state.countHigh == 8'hff);
   assign irqEdge  = state.control[CTL_IRQ_EDGE] ? (state.irqSync[1] && !state.irqPrev)
                                                 : (!state.irqSync[1] && state.irqPrev);

   always_comb begin
      next_state = state;
      next_state.phase   = state.phase + 2'h1;
      next_state.clkSync = {state.clkSync[0], extClkPin};
      next_state.irqSync = {state.irqSync[0], extIrqPin};
      next_state.clkPrev = state.clkSync[1];
      next_state.irqPrev = state.irqSync[1];
      next_state.holdLow  = 1'b0;
      next_state.holdHigh = 1'b0;
      if (state.phase == PHASE_SAMPLE_A || state.phase == PHASE_SAMPLE_B) begin
         next_state.psSample = prescalerOut;
         next_state.psPrev   = state.psSample;
      end else begin
         next_state.psPrev = state.psSample;
      end
      if (incLow)
         next_state.countLow = state.countLow + 8'h01;
      if (incHigh)
         next_state.countHigh = state.countHigh + 8'h01;
      if (pinEdge && !state.control[CTL_CLK_SRC])
         next_state.intStatus[INT_EXTCLK_FL] = 1'b1;
      if (irqEdge)
         next_state.intStatus[INT_PIN_FL] = 1'b1;
      // Vector clear, overflow set below wins in the same cycle
      if (vectorAck)
         next_state.intStatus[INT_OVF_FL] = 1'b0;
      if (state.bus != BUS_IDLE) begin
         next_state.bus = BUS_IDLE;
      end else if (access) begin
         if (!regValid) begin
            next_state.bus = BUS_ERR;
         end else begin
            next_state.bus = BUS_ACK;
            if (regIdx == REG_CONTROL)
               next_state.rdata = state.control;
            else if (regIdx == REG_CPU_STATUS)
               next_state.rdata = state.cpuStatus;
            else if (regIdx == REG_INT_STATUS)
               next_state.rdata = state.intStatus;
            else if (regIdx == REG_COUNT_LOW)
               next_state.rdata = state.countLow;
            else
               next_state.rdata = state.countHigh;
         end
         if (wrAccess) begin
            if (regIdx == REG_CONTROL) begin
               next_state.control = wb_dat_i[7:0] & CTL_WMASK;
            end else if (regIdx == REG_CPU_STATUS) begin
               next_state.cpuStatus = wb_dat_i[7:0] & CPU_WMASK;
            end else if (regIdx == REG_INT_STATUS) begin
               // Written flags may be cleared, hardware sets below win
               next_state.intStatus = wb_dat_i[7:0];
            end else if (regIdx == REG_COUNT_LOW) begin
               next_state.countLow = wb_dat_i[7:0];
               next_state.holdLow  = 1'b1;
            end else begin
               next_state.countHigh = wb_dat_i[7:0];
               next_state.holdHigh  = 1'b1;
            end
         end
      end
      if (pinEdge && !state.control[CTL_CLK_SRC])
         next_state.intStatus[INT_EXTCLK_FL] = 1'b1;
      if (irqEdge)
         next_state.intStatus[INT_PIN_FL] = 1'b1;
      if (overflow)
         next_state.intStatus[INT_OVF_FL] = 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state           <= '0;
         state.control   <= CONTROL_RESET;
         state.intStatus <= INT_RESET;
         state.cpuStatus <= CPU_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign wb_ack_o = state.bus == BUS_ACK;
   assign wb_err_o = state.bus == BUS_ERR;
   assign wb_dat_o = {24'h00_0000, state.rdata};
   assign globalIrqDisable = state.cpuStatus[CPU_GLOBAL_DIS];
   assign overflowIrq = state.intStatus[INT_OVF_FL] && state.intStatus[INT_OVF_EN];
   assign extClkIrq   = state.intStatus[INT_EXTCLK_FL] && state.intStatus[INT_EXTCLK_EN];
   assign extPinIrq   = state.intStatus[INT_PIN_FL] && state.intStatus[INT_PIN_EN];

   // A write in the wrap cycle or a held low byte legally breaks the wrap
   AST_OVF_SET: assert property (
      @(posedge mclk) disable iff (sys_rst)
      overflow && !state.holdLow && !wrAccess
      |=> state.intStatus[INT_OVF_FL] && state.countHigh == 8'h00 && state.countLow == 8'h00)
      else $error("overflow did not wrap and set flag");
   AST_OVF_MASK: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !state.intStatus[INT_OVF_EN]
      |-> !overflowIrq)
      else $error("masked overflow request raised");
   AST_VEC_CLR: assert property (
      @(posedge mclk) disable iff (sys_rst)
      vectorAck && !overflow && !(wrAccess && regIdx == REG_INT_STATUS)
      |=> !state.intStatus[INT_OVF_FL])
      else $error("vector did not clear overflow flag");
   AST_HOLD_LOW: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wrAccess && regIdx == REG_COUNT_LOW
      |=> ##1 (state.countLow == $past(wb_dat_i[7:0], 2)))
      else $error("written low byte advanced next cycle");
   AST_HIGH_CARRY: assert property (
      @(posedge mclk) disable iff (sys_rst)
      extEdge && state.countLow == 8'hff && !state.holdHigh && !wrAccess
      |=> state.countHigh == $past(state.countHigh) + 8'h01)
      else $error("high byte missed carry");
   AST_INT_SRC: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state.control[CTL_CLK_SRC] && state.phase == PHASE_LAST && !psClear
         && state.control[CTL_PS_HI:CTL_PS_LO] == 4'h0
      |=> ##[1:3] extEdge)
      else $error("internal clock did not advance");
   AST_EXT_LAT: assert property (
      @(posedge mclk) disable iff (sys_rst)
      pinEdge && !state.control[CTL_CLK_SRC] && !psClear
         && state.control[CTL_PS_HI:CTL_PS_LO] == 4'h0
      |=> ##[0:4] extEdge)
      else $error("external edge latency too long");
   AST_EXT_FLAG: assert property (
      @(posedge mclk) disable iff (sys_rst)
      pinEdge && !state.control[CTL_CLK_SRC]
      |=> state.intStatus[INT_EXTCLK_FL])
      else $error("pin edge did not set flag");
   AST_PIN_IRQ: assert property (
      @(posedge mclk) disable iff (sys_rst)
      irqEdge
      |=> state.intStatus[INT_PIN_FL])
      else $error("interrupt pin edge missed");
   AST_ONE_ACK: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wb_ack_o
      |=> !wb_ack_o)
      else $error("ack held two cycles");
   AST_ACK_NEXT: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wb_cyc_i && wb_stb_i && state.bus == BUS_IDLE
      |=> wb_ack_o || wb_err_o)
      else $error("request not answered next cycle");
   AST_ERR_UNMAPPED: assert property (
      @(posedge mclk) disable iff (sys_rst)
      access && !regValid
      |=> wb_err_o && !wb_ack_o)
      else $error("unmapped index not refused");
   AST_ERR_NO_WRITE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      access && !regValid
      |=> $stable(state.control))
      else $error("refused access changed control");
   AST_READ_LOW: assert property (
      @(posedge mclk) disable iff (sys_rst)
      access && !wb_we_i && regIdx == REG_COUNT_LOW
      |=> wb_dat_o[7:0] == $past(state.countLow))
      else $error("low byte read returned wrong value");
   AST_CTL_BIT0: assert property (
      @(posedge mclk) disable iff (sys_rst)
      1'b1
      |-> !state.control[0])
      else $error("unimplemented control bit set");
   AST_LOW_STEP: assert property (
      @(posedge mclk) disable iff (sys_rst)
      incLow && !wrAccess
      |=> state.countLow == $past(state.countLow) + 8'h01)
      else $error("low byte did not advance by one");
   AST_LOW_IDLE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !extEdge && !wrAccess
      |=> $stable(state.countLow))
      else $error("low byte moved without a count");
   AST_LOW_HOLD: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state.holdLow && !wrAccess
      |=> $stable(state.countLow))
      else $error("low byte advanced in hold cycle");
   AST_HIGH_HOLD: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state.holdHigh && !wrAccess
      |=> $stable(state.countHigh))
      else $error("high byte advanced in hold cycle");
   AST_HIGH_IDLE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !incHigh && !wrAccess
      |=> $stable(state.countHigh))
      else $error("high byte moved without a carry");
   AST_INT_NO_PIN: assert property (
      @(posedge mclk) disable iff (sys_rst)
      state.control[CTL_CLK_SRC] && state.phase != PHASE_LAST
      |=> $stable(prescalerOut))
      else $error("internal source pulsed off its phase");
   AST_EXT_UNSEL: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !state.control[CTL_CLK_SRC] && !pinEdge
      |=> $stable(prescalerOut))
      else $error("unselected pin edge reached prescaler");
   AST_SAMPLE_TWICE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !(state.phase == PHASE_SAMPLE_A || state.phase == PHASE_SAMPLE_B)
      |=> $stable(state.psSample))
      else $error("prescaler output sampled off phase");
   AST_PHASE_STEP: assert property (
      @(posedge mclk) disable iff (sys_rst)
      1'b1
      |=> state.phase == $past(state.phase) + 2'h1)
      else $error("phase counter skipped");
   AST_OVF_ONLY_WRAP: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !overflow && !(wrAccess && regIdx == REG_INT_STATUS)
      |=> !$rose(state.intStatus[INT_OVF_FL]))
      else $error("overflow flag set without a wrap");
   AST_EXT_ONLY_EDGE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !(pinEdge && !state.control[CTL_CLK_SRC]) && !(wrAccess && regIdx == REG_INT_STATUS)
      |=> !$rose(state.intStatus[INT_EXTCLK_FL]))
      else $error("clock pin flag set without an edge");
   AST_PIN_ONLY_EDGE: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !irqEdge && !(wrAccess && regIdx == REG_INT_STATUS)
      |=> !$rose(state.intStatus[INT_PIN_FL]))
      else $error("interrupt pin flag set without an edge");
   AST_EXT_MASK: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !state.intStatus[INT_EXTCLK_EN]
      |-> !extClkIrq)
      else $error("masked clock pin request raised");
   AST_PIN_MASK: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !state.intStatus[INT_PIN_EN]
      |-> !extPinIrq)
      else $error("masked interrupt pin request raised");

   COV_OVERFLOW: cover property (@(posedge mclk) disable iff (sys_rst) overflow);
   COV_WRITE_LOW: cover property (@(posedge mclk) disable iff (sys_rst) wrAccess && regIdx == REG_COUNT_LOW);
   COV_EXT_EDGE: cover property (@(posedge mclk) disable iff (sys_rst) pinEdge && !state.control[CTL_CLK_SRC]);
   COV_ERR: cover property (@(posedge mclk) disable iff (sys_rst) wb_err_o);
endmodule
`default_nettype wire

/* File: bench/pot_clk_source.sv */
/*
 External clock source model: emits a burst of pulses on the timer's clock pin.
 Assumes start is held for one mclk cycle; the pin stands low between bursts.
*/
`default_nettype none
module pot_clk_source (
   input  wire logic       mclk,
   input  wire logic       start,
   input  wire logic [7:0] numPulses,
   input  wire logic [7:0] halfPer,
   output logic            extClkPin,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      extClkPin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge mclk);
         if (start) begin
            busy <= 1'b1;
            repeat (numPulses) begin
               repeat (halfPer) @(posedge mclk);
               extClkPin <= 1'b1;
               repeat (halfPer) @(posedge mclk);
               extClkPin <= 1'b0;
            end
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/test_pot_timer.sv */
/*
 Self-checking bench for the prescaled overflow timer: byte accesses over
 Wishbone classic, prescale sweep, overflow flag, pin clock and pin interrupt.
 Assumes the one-cycle answer and the register map of pot_pkg.
*/
`default_nettype none
module test_pot_timer;
   import pot_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk, sysRst, wbCyc, wbStb, wbWe, er, psStart, vectorAck, extIrqPin;
   logic        wbAck, wbErr, extClkPin, psBusy, overflowIrq, extClkIrq, extPinIrq, globalIrqDisable;
   logic [5:0]  wbAdr;
   logic [31:0] wbDatI, wbDatO;
   logic [7:0]  numPulses, halfPer, rd;
   logic [3:0]  code;
   int          numErrors, nChecks, n, k, p;

   pot_timer u_pot_timer (.mclk(mclk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .wb_err_o(wbErr), .extClkPin(extClkPin), .extIrqPin(extIrqPin),
      .vectorAck(vectorAck), .overflowIrq(overflowIrq), .extClkIrq(extClkIrq),
      .extPinIrq(extPinIrq), .globalIrqDisable(globalIrqDisable));
   pot_clk_source u_pot_clk_source (.mclk(mclk), .start(psStart), .numPulses(numPulses),
      .halfPer(halfPer), .extClkPin(extClkPin), .busy(psBusy));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      nChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until ack or err is seen, releases at that edge
   task automatic acc(input logic we, input logic [3:0] idx, input logic [7:0] wd);
      int w;
      @(posedge mclk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {idx, 2'b00};
      wbDatI <= {24'h00_0000, wd};
      w = 0;
      do begin
         @(posedge mclk);
         w++;
      end while (wbAck !== 1'b1 && wbErr !== 1'b1 && w < 50);
      rd = wbDatO[7:0];
      er = wbErr;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (w >= 50) numErrors++;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
      acc(1'b1, idx, wd);
   endtask

   task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
      acc(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      numErrors++;
      conclude();
   end

   initial begin
      numErrors = 0;
      nChecks = 0;
      sysRst = 1'b1;
      {wbCyc, wbStb, wbWe, psStart, vectorAck, extIrqPin} = 6'h00;
      wbAdr = 6'h00;
      wbDatI = 32'h0000_0000;
      numPulses = 8'h05;
      halfPer = 8'h00;
      repeat (10) @(posedge mclk);
      sysRst <= 1'b0;
      rdc(REG_CONTROL, CONTROL_RESET);
      rdc(REG_INT_STATUS, INT_RESET);
      acc(1'b0, 4'h0, 8'h00);
      chk({7'h00, er}, 8'h01);
      wr(REG_CONTROL, 8'hff);
      rdc(REG_CONTROL, 8'hfe);
      wr(REG_CPU_STATUS, 8'h10);
      chk({7'h00, globalIrqDisable}, 8'h01);
      // Internal source 1:1, loaded low byte first with interrupts held off
      wr(REG_CONTROL, 8'h20);
      wr(REG_COUNT_LOW, 8'hf0);
      wr(REG_COUNT_HIGH, 8'hff);
      wr(REG_CPU_STATUS, 8'h00);
      n = 0;
      do begin
         acc(1'b0, REG_INT_STATUS, 8'h00);
         n++;
      end while (rd[INT_OVF_FL] !== 1'b1 && n < 100);
      chk({7'h00, rd[INT_OVF_FL]}, 8'h01);
      chk({7'h00, overflowIrq}, 8'h00);
      rdc(REG_COUNT_HIGH, 8'h00);
      wr(REG_INT_STATUS, 8'h22);
      repeat (2) @(posedge mclk);
      chk({7'h00, overflowIrq}, 8'h01);
      vectorAck <= 1'b1;
      @(posedge mclk);
      vectorAck <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({7'h00, overflowIrq}, 8'h00);
      // Read half way between the third and fourth count of each ratio from 2 to 256
      for (k = 1; k <= 9; k++) begin
         code = (k == 9) ? 4'hf : k[3:0];
         p = 4 << ((k > 8) ? 8 : k);
         wr(REG_CONTROL, {3'b001, code, 1'b0});
         wr(REG_COUNT_LOW, 8'h00);
         repeat (p * 7 / 2) @(posedge mclk);
         rdc(REG_COUNT_LOW, 8'h03);
      end
      // Full count: low read above, then high, then low again with no shrink
      rdc(REG_COUNT_HIGH, 8'h00);
      rdc(REG_COUNT_LOW, 8'h03);
      // Pin clock: slow source counting rising edges, fast one falling edges
      for (k = 1; k >= 0; k--) begin
         wr(REG_CONTROL, {1'b0, k[0], 6'h00});
         wr(REG_INT_STATUS, 8'h00);
         wr(REG_COUNT_LOW, 8'h00);
         halfPer <= k[0] ? 8'h14 : 8'h06;
         psStart <= 1'b1;
         @(posedge mclk);
         psStart <= 1'b0;
         repeat (2) @(posedge mclk);
         n = 0;
         while (psBusy !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            n++;
         end
         repeat (12) @(posedge mclk);
         rdc(REG_COUNT_LOW, 8'h05);
         chk({7'h00, extClkIrq}, 8'h00);
         acc(1'b0, REG_INT_STATUS, 8'h00);
         chk({7'h00, rd[INT_EXTCLK_FL]}, 8'h01);
      end
      // Interrupt pin: the unselected edge first, then the selected one
      for (k = 1; k >= 0; k--) begin
         // Park on the selected level, so the next move is the unselected edge
         extIrqPin <= k[0];
         wr(REG_CONTROL, {k[0], 7'h00});
         wr(REG_INT_STATUS, 8'h01);
         extIrqPin <= ~k[0];
         repeat (8) @(posedge mclk);
         chk({7'h00, extPinIrq}, 8'h00);
         extIrqPin <= k[0];
         repeat (8) @(posedge mclk);
         chk({7'h00, extPinIrq}, 8'h01);
      end
      conclude();
   end
endmodule
`default_nettype wire
